// ---- adc_cfg_consts.vh ----
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

// Timing
`define CLK_PERIOD_NS 40
`define RST_PULSE_MAX_NS 1000
`define RST_PULSE_MAX_CYC (`RST_PULSE_MAX_NS / `CLK_PERIOD_NS)

// Serial word layout
`define WORD_HALF_LAST 3'h7
`define SREG_CTRL_ADDR 8'h00
`define SREG_SW_RESET_BIT 1
`define SREG_READOUT_BIT 0
`define SREG_RESET_VAL 8'h00

// Select-pin level codes from the level comparator
`define LVL_GROUND 2'h0
`define LVL_3_8 2'h1
`define LVL_5_8 2'h2
`define LVL_FULL 2'h3

// Power-mode pin codes, first pin is the msb
`define PM_NORMAL 3'h0
`define PM_GLOBAL_PD 3'h4
`define PM_STANDBY_A 3'h5
`define PM_MUX 3'h7

// Strap capture waits until the pin synchroniser holds real levels
`define STRAP_SETTLE 2'h2
`define STRAP_DONE 2'h3

// APB register byte offsets
`define APB_STATUS 12'h000
`define APB_CONTROL 12'h004
`define APB_WORD_COUNT 12'h008
`define APB_LAST_WORD 12'h00c
`define APB_REG_INDEX 12'h010
`define APB_REG_VALUE 12'h014

// CONTROL fields and reset value
`define CTL_SERIAL_EN_BIT 0
`define CTL_SW_RESET_BIT 1
`define CTL_RESET_VAL 2'h1

`endif

// ---- adc_cfg_sva.sv ----
`timescale 1ns/10ps
module adc_cfg_sva #(
    parameter PULSE_MAX_CYC = 25
) (
    // Clock, reset, bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Pins
    input wire reset_pin,
    input wire select_bar_line,
    input wire [1:0] select_level,
    input wire shift_clock,
    input wire power_mode_pin_first,
    input wire power_mode_pin_second,
    input wire power_mode_pin_third,
    input wire readback_output_en,
    // Decoded modes
    input wire parallel_mode,
    input wire low_speed_en,
    input wire format_offset_binary,
    input wire output_lvds,
    input wire global_power_down,
    input wire standby_ch_a,
    input wire mux_mode,
    input wire power_code_invalid
);
    logic [5:0] hi_cnt;
    wire [2:0] code = {power_mode_pin_first, power_mode_pin_second, power_mode_pin_third};
    wire [3:0] pm_now = {global_power_down, standby_ch_a, mux_mode, power_code_invalid};
    wire [3:0] pm_exp = (code == 3'h4) ? 4'h8 : (code == 3'h5) ? 4'h4 :
        (code == 3'h7) ? 4'h2 : (code == 3'h0) ? 4'h0 : 4'h1;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles the reset pin has stood high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !reset_pin)
            hi_cnt <= 6'h00;
        else if (hi_cnt != 6'h3f)
            hi_cnt <= hi_cnt + 6'h01;
    end
    AST_PARALLEL_ENTRY: assert property (hi_cnt == PULSE_MAX_CYC + 6 |-> parallel_mode)
        else $error("no parallel mode after long reset pin");
    AST_PARALLEL_QUIET: assert property (parallel_mode |-> !readback_output_en)
        else $error("readback driven in parallel mode");
    AST_LOW_SPEED: assert property ((parallel_mode && $stable(shift_clock))[*6]
        |-> low_speed_en == shift_clock) else $error("low speed decode wrong");
    AST_FORMAT: assert property ((parallel_mode && $stable(select_level))[*6] |->
        format_offset_binary == ^select_level && output_lvds == select_level[1])
        else $error("format or interface decode wrong");
    AST_POWER_CODE: assert property ((parallel_mode && $stable(code))[*6]
        |-> pm_now == pm_exp) else $error("power code decode wrong");
    AST_STANDBY_ONLY: assert property (standby_ch_a |-> pm_now == 4'h4)
        else $error("standby mixed with other mode");
    AST_MUX_ONLY: assert property (mux_mode |-> pm_now == 4'h2)
        else $error("mux mixed with other mode");
    AST_READBACK_IDLE: assert property (select_bar_line[*6] |-> !readback_output_en)
        else $error("readback driven without select");
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no ready in access phase");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (parallel_mode && mux_mode);
    cover property (readback_output_en);
    cover property (pslverr);
endmodule
bind adc_config_serial_port adc_cfg_sva #(.PULSE_MAX_CYC(PULSE_MAX_CYC)) adc_cfg_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .reset_pin(reset_pin), .select_bar_line(select_bar_line),
    .select_level(select_level), .shift_clock(shift_clock),
    .power_mode_pin_first(power_mode_pin_first), .power_mode_pin_second(power_mode_pin_second),
    .power_mode_pin_third(power_mode_pin_third), .readback_output_en(readback_output_en),
    .parallel_mode(parallel_mode), .low_speed_en(low_speed_en),
    .format_offset_binary(format_offset_binary), .output_lvds(output_lvds),
    .global_power_down(global_power_down), .standby_ch_a(standby_ch_a),
    .mux_mode(mux_mode), .power_code_invalid(power_code_invalid));

// ---- adc_config_serial_port.v ----
`timescale 1ns/10ps
`include "adc_cfg_consts.vh"
module adc_config_serial_port #(
    parameter ADDR_W = 12,
    parameter REG_DEPTH = 256,
    parameter PULSE_MAX_CYC = `RST_PULSE_MAX_CYC
) (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Device pins
    input wire reset_pin,
    input wire select_bar_line,
    input wire [1:0] select_level,
    input wire shift_clock,
    input wire shift_data_in,
    input wire power_mode_pin_first,
    input wire power_mode_pin_second,
    input wire power_mode_pin_third,
    // Readback pin as output and enable
    output reg readback_output,
    output reg readback_output_en,
    // Decoded configuration
    output reg parallel_mode,
    output reg low_speed_en,
    output reg format_offset_binary,
    output reg output_lvds,
    output reg global_power_down,
    output reg standby_ch_a,
    output reg mux_mode,
    output reg power_code_invalid
);

// Serial link states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ADDR = 3'b010;
localparam [2:0] ST_DATA = 3'b100;

// Reset-pin states
localparam [2:0] RP_LOW = 3'b001;
localparam [2:0] RP_HIGH = 3'b010;
localparam [2:0] RP_PARALLEL = 3'b100;

// Synchronised pins
wire rst_pin_s;
wire sel_s;
wire sclk_s;
wire din_s;
wire [2:0] pm_s;
wire [1:0] lvl_s;

// Decoder outputs
wire dec_pd;
wire dec_sa;
wire dec_mux;
wire dec_inv;
reg [2:0] pm_code;

// Serial engine
reg [2:0] state;
reg [2:0] bit_cnt;
reg [7:0] addr_sh;
reg [7:0] data_sh;
reg [7:0] rb_sh;
reg sclk_d;
wire sclk_fall;
reg word_done;
reg [7:0] word_addr;
reg [7:0] word_data;

// Serial register array
reg [7:0] sreg [0:REG_DEPTH-1];
integer i;

// Reset-pin handling
reg [2:0] rp_state;
reg [5:0] rp_cnt;
reg pin_reset;
reg [1:0] strap_wait;
reg [2:0] pm_strap;

// APB-side registers
reg [1:0] control;
reg [15:0] word_count;
reg [16:0] last_word;
reg [7:0] reg_index;
reg apb_sw_reset;
wire apb_wr;
wire apb_setup;
reg [31:0] next_prdata;
reg next_pslverr;

wire readout_on;
wire serial_live;
wire defaults_load;

// Pin synchronisers
sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_rst (
    .clk(pclk), .rst_n(presetn), .d(reset_pin), .q(rst_pin_s));
sync_2ff #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_sel (
    .clk(pclk), .rst_n(presetn), .d(select_bar_line), .q(sel_s));
sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_sclk (
    .clk(pclk), .rst_n(presetn), .d(shift_clock), .q(sclk_s));
sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_din (
    .clk(pclk), .rst_n(presetn), .d(shift_data_in), .q(din_s));
sync_2ff #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync_pm (
    .clk(pclk), .rst_n(presetn), .q(pm_s),
    .d({power_mode_pin_first, power_mode_pin_second, power_mode_pin_third}));
sync_2ff #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_lvl (
    .clk(pclk), .rst_n(presetn), .d(select_level), .q(lvl_s));

// Power-mode decoder
power_mode_decode u_pm_dec (
    .code(pm_code), .global_pd(dec_pd), .standby_a(dec_sa), .mux_mode(dec_mux),
    .invalid(dec_inv));

// Live pins in parallel mode, power-up straps otherwise
always @* begin
    pm_code = parallel_mode ? pm_s : pm_strap;
end

// Reset pin: short pulse resets registers, long high means parallel
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rp_state <= RP_LOW;
        rp_cnt <= 6'h00;
        pin_reset <= 1'b0;
    end else begin
        pin_reset <= 1'b0;
        case (rp_state)
            RP_LOW: begin
                rp_cnt <= 6'h00;
                if (rst_pin_s) begin
                    rp_state <= RP_HIGH;
                end
            end
            RP_HIGH: begin
                if (!rst_pin_s) begin
                    pin_reset <= 1'b1;
                    rp_state <= RP_LOW;
                end else if (rp_cnt == PULSE_MAX_CYC[5:0]) begin
                    rp_state <= RP_PARALLEL;
                end else begin
                    rp_cnt <= rp_cnt + 6'h01;
                end
            end
            RP_PARALLEL: begin
                if (!rst_pin_s) begin
                    pin_reset <= 1'b1;
                    rp_state <= RP_LOW;
                end
            end
            default: rp_state <= RP_LOW;
        endcase
    end
end

// Capture straps once, after the synchroniser has flushed its reset value
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strap_wait <= 2'h0;
        pm_strap <= `PM_NORMAL;
    end else if (strap_wait != `STRAP_DONE) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == `STRAP_SETTLE) begin
            pm_strap <= pm_s;
        end
    end
end

// Configuration outputs
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        parallel_mode <= 1'b0;
        low_speed_en <= 1'b0;
        format_offset_binary <= 1'b0;
        output_lvds <= 1'b0;
        global_power_down <= 1'b0;
        standby_ch_a <= 1'b0;
        mux_mode <= 1'b0;
        power_code_invalid <= 1'b0;
    end else begin
        parallel_mode <= (rp_state == RP_PARALLEL);
        if (rp_state == RP_PARALLEL) begin
            low_speed_en <= sclk_s;
            format_offset_binary <= (lvl_s == `LVL_3_8) || (lvl_s == `LVL_5_8);
            output_lvds <= (lvl_s == `LVL_5_8) || (lvl_s == `LVL_FULL);
        end
        global_power_down <= dec_pd;
        standby_ch_a <= dec_sa;
        mux_mode <= dec_mux;
        power_code_invalid <= dec_inv;
    end
end

assign readout_on = sreg[`SREG_CTRL_ADDR][`SREG_READOUT_BIT];
// Serial port is dead in parallel mode and while the pin is high
assign serial_live = (rp_state == RP_LOW) && control[`CTL_SERIAL_EN_BIT];
assign sclk_fall = sclk_d && !sclk_s;

// Serial shifter: address first, then data, msb first
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
        sclk_d <= 1'b0;
        bit_cnt <= 3'h0;
        addr_sh <= 8'h00;
        data_sh <= 8'h00;
        rb_sh <= 8'h00;
        word_done <= 1'b0;
        word_addr <= 8'h00;
        word_data <= 8'h00;
        readback_output <= 1'b0;
        readback_output_en <= 1'b0;
    end else begin
        sclk_d <= sclk_s;
        word_done <= 1'b0;
        readback_output <= rb_sh[7];
        readback_output_en <= readout_on && (state == ST_DATA);
        if (sel_s || !serial_live) begin
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_ADDR;
                    bit_cnt <= 3'h0;
                end
                ST_ADDR: begin
                    if (sclk_fall) begin
                        addr_sh <= {addr_sh[6:0], din_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `WORD_HALF_LAST) begin
                            state <= ST_DATA;
                            rb_sh <= sreg[{addr_sh[6:0], din_s}];
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_fall) begin
                        data_sh <= {data_sh[6:0], din_s};
                        rb_sh <= {rb_sh[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `WORD_HALF_LAST) begin
                            word_done <= 1'b1;
                            word_addr <= addr_sh;
                            word_data <= {data_sh[6:0], din_s};
                            state <= ST_ADDR;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
end

// Pin and APB resets reload defaults, the serial reset only while readout is off
assign defaults_load = pin_reset || apb_sw_reset || (rp_state != RP_LOW) ||
    (word_done && (word_addr == `SREG_CTRL_ADDR) && word_data[`SREG_SW_RESET_BIT] &&
     !readout_on);

// Serial register array
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (i = 0; i < REG_DEPTH; i = i + 1) begin
            sreg[i] <= `SREG_RESET_VAL;
        end
    end else if (defaults_load) begin
        for (i = 0; i < REG_DEPTH; i = i + 1) begin
            sreg[i] <= `SREG_RESET_VAL;
        end
    end else if (word_done && (!readout_on || word_addr == `SREG_CTRL_ADDR)) begin
        sreg[word_addr] <= word_data;
    end
end

assign apb_setup = psel && !penable;
assign apb_wr = psel && penable && pready && pwrite;

// Read mux and error decode, taken in the setup phase
always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
        `APB_STATUS: next_prdata = {20'h00000, pm_strap, readout_on,
            power_code_invalid, mux_mode, standby_ch_a, global_power_down,
            output_lvds, format_offset_binary, low_speed_en, parallel_mode};
        `APB_CONTROL: next_prdata = {30'h00000000, control};
        `APB_WORD_COUNT: next_prdata = {16'h0000, word_count};
        `APB_LAST_WORD: next_prdata = {15'h0000, last_word};
        `APB_REG_INDEX: next_prdata = {24'h000000, reg_index};
        `APB_REG_VALUE: next_prdata = {24'h000000, sreg[reg_index]};
        default: next_pslverr = 1'b1;
    endcase
end

// APB slave: zero-wait answer, writes land at the access edge
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
        control <= `CTL_RESET_VAL;
        reg_index <= 8'h00;
        apb_sw_reset <= 1'b0;
    end else begin
        pready <= apb_setup;
        apb_sw_reset <= 1'b0;
        if (apb_setup) begin
            prdata <= next_pslverr ? 32'h00000000 : next_prdata;
            pslverr <= next_pslverr;
        end else begin
            pslverr <= 1'b0;
        end
        if (apb_wr && paddr == `APB_CONTROL) begin
            control[`CTL_SERIAL_EN_BIT] <= pwdata[`CTL_SERIAL_EN_BIT];
            apb_sw_reset <= pwdata[`CTL_SW_RESET_BIT];
        end
        if (apb_wr && paddr == `APB_REG_INDEX) begin
            reg_index <= pwdata[7:0];
        end
    end
end

// Word counter and last received word, bit 16 set if readout blocked its write
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        word_count <= 16'h0000;
        last_word <= 17'h00000;
    end else if (word_done) begin
        word_count <= word_count + 16'h0001;
        last_word <= {readout_on && (word_addr != `SREG_CTRL_ADDR), word_addr, word_data};
    end
end

endmodule

// ---- adc_config_serial_port_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_config_serial_port_tb;
    logic pclk, presetn, psel, penable, pwrite, reset_pin, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] select_level;
    logic [2:0] pm;
    logic select_bar_line, shift_clock, shift_data_in, readback_output, readback_output_en;
    logic parallel_mode, low_speed_en, format_offset_binary, output_lvds;
    logic global_power_down, standby_ch_a, mux_mode, power_code_invalid;
    wire [3:0] pm_out = {global_power_down, standby_ch_a, mux_mode, power_code_invalid};
    integer n_mismatch = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    adc_config_serial_port #(.PULSE_MAX_CYC(4)) adc_config_serial_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin(reset_pin), .select_bar_line(select_bar_line),
        .select_level(select_level), .shift_clock(shift_clock), .shift_data_in(shift_data_in),
        .power_mode_pin_first(pm[2]), .power_mode_pin_second(pm[1]),
        .power_mode_pin_third(pm[0]), .readback_output(readback_output),
        .readback_output_en(readback_output_en), .parallel_mode(parallel_mode),
        .low_speed_en(low_speed_en), .format_offset_binary(format_offset_binary),
        .output_lvds(output_lvds), .global_power_down(global_power_down),
        .standby_ch_a(standby_ch_a), .mux_mode(mux_mode),
        .power_code_invalid(power_code_invalid));
    serial_ctrl_model serial_ctrl_model_inst (
        .select_bar_line(select_bar_line), .shift_clock(shift_clock),
        .shift_data_in(shift_data_in), .readback_output(readback_output),
        .readback_output_en(readback_output_en));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run;
        end
    end
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One bus transfer, result in rd and err
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Serial register value through the index window
    task automatic sreg(input logic [7:0] a);
        apb(1'b1, 12'h010, {24'h0, a});
        apb(1'b0, 12'h014, 32'h0);
    endtask
    task automatic wr(input logic [15:0] w);
        serial_ctrl_model_inst.xfer({16'h0, w}, 16, 1'b1);
    endtask
    task t_power_up;
        `CHK({global_power_down, standby_ch_a, mux_mode}, 3'b010)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd, 32'h1)
        apb(1'b0, 12'h018, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task t_words;
        wr(16'h03a5);
        sreg(8'h03);
        `CHK(rd[7:0], 8'ha5)
        serial_ctrl_model_inst.hi_ns = 190;
        serial_ctrl_model_inst.lo_ns = 130;
        serial_ctrl_model_inst.xfer(32'h253c2918, 32, 1'b1);
        serial_ctrl_model_inst.hi_ns = 160;
        serial_ctrl_model_inst.lo_ns = 160;
        sreg(8'h25);
        `CHK(rd[7:0], 8'h3c)
        sreg(8'h29);
        `CHK(rd[7:0], 8'h18)
        serial_ctrl_model_inst.xfer({1'b0, 16'h4077, 15'h20ff}, 31, 1'b1);
        sreg(8'h40);
        `CHK(rd[7:0], 8'h77)
        sreg(8'h41);
        `CHK(rd[7:0], 8'h00)
        serial_ctrl_model_inst.xfer(32'h50aa, 16, 1'b0);
        sreg(8'h50);
        `CHK(rd[7:0], 8'h00)
    endtask
    task t_readback;
        wr(16'h0001);
        wr(16'h03ff);
        wr(16'h0300);
        `CHK(serial_ctrl_model_inst.rb, 8'ha5)
        wr(16'h0000);
        repeat (8) @(posedge pclk);
        `CHK(readback_output_en, 1'b0)
        wr(16'h035a);
        sreg(8'h03);
        `CHK(rd[7:0], 8'h5a)
    endtask
    task t_resets;
        wr(16'h0002);
        sreg(8'h03);
        `CHK(rd[7:0], 8'h00)
        sreg(8'h00);
        `CHK(rd[7:0], 8'h00)
        wr(16'h0377);
        reset_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        reset_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        sreg(8'h03);
        `CHK(rd[7:0], 8'h00)
        `CHK(parallel_mode, 1'b0)
    endtask
    task t_parallel;
        integer i;
        logic [3:0] pm_exp;
        reset_pin <= 1'b1;
        repeat (20) @(posedge pclk);
        `CHK(parallel_mode, 1'b1)
        for (i = 0; i < 4; i++) begin
            select_level <= i[1:0];
            serial_ctrl_model_inst.shift_clock <= i[0];
            serial_ctrl_model_inst.shift_data_in <= !i[0];
            repeat (8) @(posedge pclk);
            `CHK({format_offset_binary, output_lvds}, {i[1] ^ i[0], i[1]})
            `CHK(low_speed_en, i[0])
            `CHK(readback_output_en, 1'b0)
        end
        for (i = 0; i < 8; i++) begin
            pm <= i[2:0];
            repeat (8) @(posedge pclk);
            pm_exp = (i == 4) ? 4'h8 : (i == 5) ? 4'h4 : (i == 7) ? 4'h2 :
                (i == 0) ? 4'h0 : 4'h1;
            `CHK(pm_out, pm_exp)
        end
    endtask
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_pin = 1'b0;
        select_level = 2'h0;
        pm = 3'h5;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        t_power_up;
        t_words;
        t_readback;
        t_resets;
        t_parallel;
        complete_run;
    end
endmodule

// ---- power_mode_decode.v ----
`timescale 1ns/10ps
`include "adc_cfg_consts.vh"
module power_mode_decode (
    // Three power-mode pin levels, first pin in bit 2
    input wire [2:0] code,
    // Decoded modes
    output reg global_pd,
    output reg standby_a,
    output reg mux_mode,
    output reg invalid
);

// Code to mode map; unavailable codes fall back to normal and flag
always @* begin
    global_pd = 1'b0;
    standby_a = 1'b0;
    mux_mode = 1'b0;
    invalid = 1'b0;
    case (code)
        `PM_NORMAL: invalid = 1'b0;
        `PM_GLOBAL_PD: global_pd = 1'b1;
        `PM_STANDBY_A: standby_a = 1'b1;
        `PM_MUX: mux_mode = 1'b1;
        default: invalid = 1'b1;
    endcase
end

endmodule

// ---- serial_ctrl_model.sv ----
`timescale 1ns/10ps
module serial_ctrl_model (
    // Serial lines
    output logic select_bar_line,
    output logic shift_clock,
    output logic shift_data_in,
    // Readback pin
    input wire logic readback_output,
    input wire logic readback_output_en
);
    integer hi_ns = 160;
    integer lo_ns = 160;
    logic [7:0] rb;
    // Idle: deselected, clock parked high
    initial begin
        select_bar_line = 1'b1;
        shift_clock = 1'b1;
        shift_data_in = 1'b0;
    end
    // Send n bits, first bit is bits[n-1]
    task automatic xfer(input logic [31:0] bits, input integer n, input bit sel_on);
        integer i;
        #5;
        select_bar_line = !sel_on;
        #200;
        for (i = n - 1; i >= 0; i--) begin
            shift_data_in = bits[i];
            #(hi_ns);
            if ((n - 1 - i) % 16 >= 8)
                rb = {rb[6:0], readback_output_en ? readback_output : 1'bx};
            shift_clock = 1'b0;
            #(lo_ns);
            shift_clock = 1'b1;
        end
        #200;
        select_bar_line = 1'b1;
        shift_data_in = !shift_data_in; // Released line is not held
        #200;
    endtask
endmodule

// ---- sync_2ff.v ----
`timescale 1ns/10ps
module sync_2ff #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Asynchronous level in, synchronised level out
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta;

// Two-stage synchroniser, first stage read only by the second
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta <= RESET_VAL;
        q <= RESET_VAL;
    end else begin
        meta <= d;
        q <= meta;
    end
end

endmodule
